// ---- rtl/dmahs_device.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dmahs_defs.svh"
// Summary of operation
// - Acknowledge shows grant or master bus ownership
// - Request and acknowledge polarity are selectable
// - Slave selected by acknowledge plus command
// - Master waits for acknowledge before MASTER#
// - No acknowledge if request already withdrew
// - Acknowledges high in reset and suspend
// - Requester holds request until acknowledged
// - Request edges treated as asynchronous
// - PCI agent requests on active-low line
// - Grant PCI agents on active-low grant
// - All pairs act as spare pins when PCI DMA is disabled
// - Grants high in reset, suspend high/spare
// - Terminal count after last transfer address
// - Terminal count held until address enable drops
// - Autoinit drops terminal count before address enable
// - Terminal count low in reset and suspend
module dmahs_device
    import dmahs_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        srst,
    dmahs_if.device                          bus,
    input  wire logic                        req_active_low,
    input  wire logic                        ack_active_low,
    input  wire logic                        pci_dma_enable,
    input  wire logic                        suspend,
    input  wire logic                        suspend_gpo_sel,
    input  wire logic [`DMAHS_NUM_PAIRS-1:0] spare_output_pins,
    output logic      [`DMAHS_NUM_PAIRS-1:0] spare_input_pins,
    input  wire logic                        xfer_addr_out,
    input  wire logic                        count_expired,
    input  wire logic                        autoinit,
    input  wire logic                        xfer_done,
    output logic                             busy,
    output logic      [2:0]                  active_ch,
    output logic      [`DMAHS_NUM_PAIRS-1:0] pci_req_seen
);
    dmahs_state_t state;
    dmahs_state_t next_state;
    logic [`DMAHS_NUM_CH-1:0]    req_sync;
    logic [`DMAHS_NUM_PAIRS-1:0] pci_sync;
    logic [`DMAHS_NUM_CH-1:0]    ack_onehot;
    logic [2:0]                  ch;
    logic                        tc;
    logic                        aen;
    logic [`DMAHS_NUM_PAIRS-1:0] gnt;
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Literal widths below assume seven channels and three pairs
    if ((`DMAHS_NUM_CH != 7) || (`DMAHS_NUM_PAIRS != 3)) begin : g_size_check
        $error("channel or pair count not supported");
    end
    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    dmahs_sync #(.WIDTH(`DMAHS_NUM_CH)) u_req_sync (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .async_in  (bus.dma_req),
        .reset_val ({`DMAHS_NUM_CH{req_active_low}}),
        .sync_out  (req_sync)
    );
    dmahs_sync #(.WIDTH(`DMAHS_NUM_PAIRS)) u_pci_sync (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .async_in  (bus.pci_req_n),
        .reset_val (`DMAHS_GNT_IDLE),
        .sync_out  (pci_sync)
    );
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic [2:0] dmahs_pick(input logic [`DMAHS_NUM_CH-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = `DMAHS_NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction
    // Polarity is sampled live: switching it outside suspend lets stale synchroniser
    // levels look like fresh requests for two edges
    wire [`DMAHS_NUM_CH-1:0] req_act  = req_sync ^ {`DMAHS_NUM_CH{req_active_low}};
    wire                     any_req  = |req_act;
    wire [2:0]               pick     = dmahs_pick(req_act);
    wire                     still_rq = req_act[ch];
    wire [`DMAHS_NUM_PAIRS-1:0] pci_act = ~pci_sync;
    assign spare_input_pins = pci_sync;
    assign pci_req_seen     = pci_dma_enable ? pci_act : 3'h0;
    always_comb begin
        next_state = state;
        case (state)
            DMAHS_IDLE: begin
                if (any_req && !suspend) begin
                    next_state = DMAHS_GRANT;
                end
            end
            DMAHS_GRANT: begin
                // Request dropped before grant: back out without acking
                if (!still_rq) begin
                    next_state = DMAHS_IDLE;
                end else begin
                    next_state = DMAHS_XFER;
                end
            end
            DMAHS_XFER: begin
                if (xfer_done) begin
                    next_state = autoinit ? DMAHS_AUTOINIT : DMAHS_IDLE;
                end
            end
            DMAHS_AUTOINIT: begin
                next_state = DMAHS_IDLE;
            end
            default: begin
                next_state = DMAHS_IDLE;
            end
        endcase
    end
    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst || suspend) begin
            state <= DMAHS_IDLE;
            ch    <= 3'h0;
        end else begin
            state <= next_state;
            if (state == DMAHS_IDLE) begin
                ch <= pick;
            end
        end
    end
    // ----------------------------------------
    // Terminal count and address enable
    // ----------------------------------------
    // A count expiring on the closing cycle is dropped with AEN, or a cycle before it on autoinit, never after it
    wire tc_event = (state == DMAHS_XFER) && xfer_addr_out && count_expired;
    always_ff @(posedge sys_clk) begin
        if (srst || suspend) begin
            tc  <= `DMAHS_TC_IDLE;
            aen <= 1'h0;
        end else begin
            aen <= (next_state == DMAHS_XFER) || (next_state == DMAHS_AUTOINIT);
            if (next_state == DMAHS_AUTOINIT) begin
                // Autoinit drops the count a cycle ahead of AEN
                tc <= 1'h0;
            end else if (next_state == DMAHS_IDLE) begin
                tc <= 1'h0;
            end else if (tc_event) begin
                tc <= 1'h1;
            end
        end
    end
    // ----------------------------------------
    // PCI grants, one pair served at a time
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gnt <= 3'h0;
        end else if (!pci_dma_enable || suspend) begin
            gnt <= 3'h0;
        end else if (gnt == 3'h0) begin
            gnt <= pci_act & ~(pci_act - 3'h1);
        end else begin
            gnt <= gnt & pci_act;
        end
    end
    wire [`DMAHS_NUM_PAIRS-1:0] gnt_pins = ~gnt;
    wire [`DMAHS_NUM_PAIRS-1:0] susp_gnt = suspend_gpo_sel ? spare_output_pins
                                                            : `DMAHS_GNT_IDLE;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus.pci_gnt_n <= `DMAHS_GNT_IDLE;
        end else if (suspend) begin
            bus.pci_gnt_n <= susp_gnt;
        end else if (!pci_dma_enable) begin
            bus.pci_gnt_n <= spare_output_pins;
        end else begin
            bus.pci_gnt_n <= gnt_pins;
        end
    end
    // ----------------------------------------
    // Acknowledge outputs
    // ----------------------------------------
    wire ack_on = (state == DMAHS_XFER) || (state == DMAHS_AUTOINIT);
    assign ack_onehot = ack_on ? (7'h01 << ch) : 7'h00;
    // Registered so the pins never glitch while the channel changes
    always_ff @(posedge sys_clk) begin
        if (srst || suspend) begin
            bus.dma_ack <= `DMAHS_ACK_IDLE;
        end else begin
            bus.dma_ack <= ack_onehot ^ {`DMAHS_NUM_CH{ack_active_low}};
        end
    end
    assign bus.term_count = tc;
    assign bus.addr_en    = aen;
    assign busy           = ack_on;
    assign active_ch      = ch;
endmodule // dmahs_device
`default_nettype wire

// ---- rtl/dmahs_defs.svh ----
`ifndef DMAHS_DEFS_SVH
`define DMAHS_DEFS_SVH
// ----------------------------------------
// Channel and pair counts
// ----------------------------------------
`define DMAHS_NUM_CH      7
`define DMAHS_NUM_PAIRS   3
// ----------------------------------------
// Reset and idle levels, synchroniser depth
// ----------------------------------------
`define DMAHS_ACK_IDLE    7'h7f
`define DMAHS_GNT_IDLE    3'h7
`define DMAHS_TC_IDLE     1'h0
`define DMAHS_SYNC_STAGES 2
`endif

// ---- rtl/dmahs_pkg.sv ----
package dmahs_pkg;
    typedef enum logic [1:0] {
        DMAHS_IDLE,
        DMAHS_GRANT,
        DMAHS_XFER,
        DMAHS_AUTOINIT
    } dmahs_state_t;
endpackage

// ---- rtl/dmahs_if.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dmahs_defs.svh"
interface dmahs_if;
    logic [`DMAHS_NUM_CH-1:0]    dma_req;
    logic [`DMAHS_NUM_CH-1:0]    dma_ack;
    logic                        io_cmd;
    logic                        master_n;
    logic                        term_count;
    logic                        addr_en;
    logic [`DMAHS_NUM_PAIRS-1:0] pci_req_n;
    logic [`DMAHS_NUM_PAIRS-1:0] pci_gnt_n;
    modport device (
        input  dma_req,
        input  io_cmd,
        input  master_n,
        input  pci_req_n,
        output dma_ack,
        output term_count,
        output addr_en,
        output pci_gnt_n
    );
    modport agent (
        output dma_req,
        output io_cmd,
        output master_n,
        output pci_req_n,
        input  dma_ack,
        input  term_count,
        input  addr_en,
        input  pci_gnt_n
    );
endinterface
`default_nettype wire

// ---- rtl/dmahs_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dmahs_defs.svh"
module dmahs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    // The first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage1   <= reset_val;
            sync_out <= reset_val;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // dmahs_sync
`default_nettype wire

// ---- rtl/dmahs_agent.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dmahs_defs.svh"
module dmahs_agent
    import dmahs_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        srst,
    dmahs_if.agent                           bus,
    input  wire logic                        req_active_low,
    input  wire logic                        ack_active_low,
    input  wire logic [`DMAHS_NUM_CH-1:0]    want,
    input  wire logic                        is_master,
    input  wire logic                        io_strobe,
    input  wire logic [`DMAHS_NUM_PAIRS-1:0] pci_want,
    output logic      [`DMAHS_NUM_CH-1:0]    selected,
    output logic      [`DMAHS_NUM_PAIRS-1:0] pci_granted,
    output logic                             tc_seen
);
    logic [`DMAHS_NUM_CH-1:0]    pend;
    logic [`DMAHS_NUM_CH-1:0]    ack_s;
    logic [`DMAHS_NUM_PAIRS-1:0] gnt_s;
    logic                        tc_s;
    dmahs_sync #(.WIDTH(`DMAHS_NUM_CH)) u_ack_sync (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .async_in  (bus.dma_ack),
        .reset_val ({`DMAHS_NUM_CH{ack_active_low}}),
        .sync_out  (ack_s)
    );
    dmahs_sync #(.WIDTH(`DMAHS_NUM_PAIRS + 1)) u_misc_sync (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .async_in  ({bus.pci_gnt_n, bus.term_count}),
        .reset_val ({`DMAHS_GNT_IDLE, `DMAHS_TC_IDLE}),
        .sync_out  ({gnt_s, tc_s})
    );
    wire [`DMAHS_NUM_CH-1:0] ack_act = ack_s ^ {`DMAHS_NUM_CH{ack_active_low}};
    // Requests latch until acknowledged, then drop
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pend <= 7'h00;
        end else begin
            pend <= (pend | want) & ~ack_act;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus.dma_req   <= {`DMAHS_NUM_CH{req_active_low}};
            bus.pci_req_n <= `DMAHS_GNT_IDLE;
            bus.master_n  <= 1'h1;
        end else begin
            bus.dma_req   <= (pend | want) ^ {`DMAHS_NUM_CH{req_active_low}};
            bus.pci_req_n <= ~pci_want;
            bus.master_n  <= ~(is_master && (|ack_act));
        end
    end
    assign bus.io_cmd  = io_strobe;
    assign selected    = io_strobe ? ack_act : 7'h00;
    assign pci_granted = ~gnt_s;
    assign tc_seen     = tc_s;
endmodule // dmahs_agent
`default_nettype wire

// ---- tb/dmahs_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dmahs_defs.svh"
module dmahs_checker (
    input wire logic                        sys_clk,
    input wire logic                        srst,
    input wire logic [`DMAHS_NUM_CH-1:0]    dma_req,
    input wire logic [`DMAHS_NUM_CH-1:0]    dma_ack,
    input wire logic                        io_cmd,
    input wire logic                        master_n,
    input wire logic                        term_count,
    input wire logic                        addr_en,
    input wire logic [`DMAHS_NUM_PAIRS-1:0] pci_req_n,
    input wire logic [`DMAHS_NUM_PAIRS-1:0] pci_gnt_n
);
    // ----------------------------------------
    // Reset levels, with no disable so reset itself is seen
    // ----------------------------------------
    property p_ack_rst;
        @(posedge sys_clk) srst |=> dma_ack == `DMAHS_ACK_IDLE;
    endproperty
    a_ack_rst: assert property (p_ack_rst)
        else $error("ack not idle in reset");
    property p_gnt_rst;
        @(posedge sys_clk) srst |=> pci_gnt_n == `DMAHS_GNT_IDLE;
    endproperty
    a_gnt_rst: assert property (p_gnt_rst)
        else $error("grant not idle in reset");
    property p_tc_rst;
        @(posedge sys_clk) srst |=> term_count == `DMAHS_TC_IDLE;
    endproperty
    a_tc_rst: assert property (p_tc_rst)
        else $error("terminal count not low in reset");
    // ----------------------------------------
    // Handshake and terminal count
    // ----------------------------------------
    // Two sync stages plus grant: no acknowledge for three edges
    property p_sync_delay;
        @(posedge sys_clk) disable iff (srst)
        $fell(srst) |-> (dma_ack == `DMAHS_ACK_IDLE) [*3];
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("acknowledge too early after reset");
    property p_ack_one;
        @(posedge sys_clk) disable iff (srst) $onehot0(dma_ack) || $onehot0(~dma_ack);
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("more than one acknowledge active");
    property p_gnt_one;
        @(posedge sys_clk) disable iff (srst) $onehot0(~pci_gnt_n);
    endproperty
    a_gnt_one: assert property (p_gnt_one)
        else $error("more than one grant low");
    property p_tc_aen;
        @(posedge sys_clk) disable iff (srst) term_count |-> addr_en;
    endproperty
    a_tc_aen: assert property (p_tc_aen)
        else $error("terminal count without address enable");
    property p_tc_rise;
        @(posedge sys_clk) disable iff (srst) $rose(term_count) |-> $past(addr_en);
    endproperty
    a_tc_rise: assert property (p_tc_rise)
        else $error("terminal count before transfer address");
    sequence s_tc_drop_first;
        term_count ##1 (addr_en && !term_count);
    endsequence
    property p_ai;
        @(posedge sys_clk) disable iff (srst) s_tc_drop_first |=> !addr_en;
    endproperty
    a_ai: assert property (p_ai)
        else $error("address enable not dropped after autoinit");
endmodule // dmahs_checker
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dmahs_defs.svh"
module testbench;
    logic       sys_clk = 1'b0;
    logic       srst    = 1'b1;
    logic       rq_lo   = 1'b0;
    logic       ak_lo   = 1'b1;
    logic       pen     = 1'b1;
    logic       susp    = 1'b0;
    logic       gsel    = 1'b0;
    logic [2:0] spare_o = 3'h0;
    logic [2:0] spare_i;
    logic       a_out   = 1'b0;
    logic       c_exp   = 1'b0;
    logic       ainit   = 1'b0;
    logic       done_p  = 1'b0;
    logic [6:0] want    = 7'h00;
    logic       io_stb  = 1'b0;
    logic [2:0] pwant   = 3'h0;
    logic [6:0] sel;
    logic       mstr    = 1'b0;
    logic       busy_o;
    logic [2:0] ach;
    logic [2:0] pseen;
    logic [2:0] pgrant;
    logic       tcs;
    int         fails       = 0;
    int         check_count = 0;
    int         cyc         = 0;
    dmahs_if i_dmahs_if ();
    dmahs_device i_dmahs_device (.sys_clk(sys_clk), .srst(srst), .bus(i_dmahs_if),
        .req_active_low(rq_lo), .ack_active_low(ak_lo), .pci_dma_enable(pen),
        .suspend(susp), .suspend_gpo_sel(gsel), .spare_output_pins(spare_o),
        .spare_input_pins(spare_i), .xfer_addr_out(a_out), .count_expired(c_exp),
        .autoinit(ainit), .xfer_done(done_p), .busy(busy_o), .active_ch(ach),
        .pci_req_seen(pseen));
    dmahs_agent i_dmahs_agent (.sys_clk(sys_clk), .srst(srst), .bus(i_dmahs_if),
        .req_active_low(rq_lo), .ack_active_low(ak_lo), .want(want), .is_master(mstr),
        .io_strobe(io_stb), .pci_want(pwant), .selected(sel), .pci_granted(pgrant),
        .tc_seen(tcs));
    dmahs_checker i_dmahs_checker (.sys_clk(sys_clk), .srst(srst),
        .dma_req(i_dmahs_if.dma_req), .dma_ack(i_dmahs_if.dma_ack),
        .io_cmd(i_dmahs_if.io_cmd), .master_n(i_dmahs_if.master_n),
        .term_count(i_dmahs_if.term_count), .addr_en(i_dmahs_if.addr_en),
        .pci_req_n(i_dmahs_if.pci_req_n), .pci_gnt_n(i_dmahs_if.pci_gnt_n));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Channel 7 does not exist, so act(7) gives the idle pattern
    function automatic logic [6:0] act(input int ch);
        logic [7:0] one;
        one = 8'h01 << ch;
        act = (ak_lo ? 7'h7f : 7'h00) ^ one[6:0];
    endfunction
    task automatic run(input int ch, input logic last, input logic ai);
        int n;
        want[ch] = 1'b1;
        tick(1);
        want[ch] = 1'b0;
        tick(1);
        chk(8'(i_dmahs_if.dma_ack), 8'(act(7)));
        n = 0;
        while (i_dmahs_if.dma_ack !== act(ch) && n < 20) begin
            tick(1);
            n++;
        end
        chk(8'(i_dmahs_if.dma_ack), 8'(act(ch)));
        chk(8'({busy_o, ach}), 8'h08 | 8'(ch));
        chk(8'(i_dmahs_if.master_n), 8'h01);
        io_stb = 1'b1;
        tick(4);
        chk(8'(sel), 8'h01 << ch);
        chk(8'(i_dmahs_if.master_n), 8'(!mstr));
        io_stb = 1'b0;
        a_out = 1'b1;
        c_exp = last;
        tick(1);
        a_out = 1'b0;
        c_exp = 1'b0;
        tick(2);
        chk(8'(i_dmahs_if.term_count), 8'(last));
        chk(8'(tcs), 8'(last));
        // Autoinit only counts when it comes with the closing strobe
        ainit = ai;
        done_p = 1'b1;
        tick(1);
        ainit = 1'b0;
        done_p = 1'b0;
        if (ai) chk(8'({i_dmahs_if.addr_en, i_dmahs_if.term_count}), 8'h02);
        tick(3);
        chk(8'({i_dmahs_if.addr_en, i_dmahs_if.term_count}), 8'h00);
        chk(8'(i_dmahs_if.dma_ack), 8'(act(7)));
        chk(8'(busy_o), 8'h00);
    endtask
    // Polarity moves only in suspend, so stale synchronised levels are never taken
    task automatic set_pol(input logic rq, input logic ak);
        susp = 1'b1;
        rq_lo = rq;
        ak_lo = ak;
        tick(4);
        susp = 1'b0;
        tick(4);
    endtask
    initial begin
        tick(1);
        chk(8'(i_dmahs_if.dma_ack), 8'h7f);
        chk(8'(i_dmahs_if.pci_gnt_n), 8'h07);
        chk(8'(i_dmahs_if.term_count), 8'h00);
        tick(1);
        srst = 1'b0;
        for (int ch = 0; ch < 7; ch++) begin
            mstr = ch[1];
            run(ch, ch[0], ch == 3);
        end
        $display("channel test done");
        set_pol(1'b1, 1'b0);
        run(5, 1'b0, 1'b0);
        set_pol(1'b0, 1'b1);
        $display("polarity test done");
        for (int p = 0; p < 3; p++) begin
            pwant[p] = 1'b1;
            tick(8);
            chk(8'(i_dmahs_if.pci_gnt_n), 8'h07 ^ (8'h01 << p));
            chk(8'(pgrant), 8'h01 << p);
            chk(8'(pseen), 8'h01 << p);
            pwant[p] = 1'b0;
            tick(8);
            chk(8'(i_dmahs_if.pci_gnt_n), 8'h07);
            chk(8'({pgrant, pseen}), 8'h00);
        end
        $display("grant test done");
        susp = 1'b1;
        pwant = 3'h1;
        tick(6);
        chk(8'(i_dmahs_if.pci_gnt_n), 8'h07);
        chk(8'(i_dmahs_if.dma_ack), 8'h7f);
        chk(8'(i_dmahs_if.term_count), 8'h00);
        gsel = 1'b1;
        spare_o = 3'h6;
        tick(2);
        chk(8'(i_dmahs_if.pci_gnt_n), 8'h06);
        susp = 1'b0;
        gsel = 1'b0;
        pwant = 3'h4;
        pen = 1'b0;
        spare_o = 3'h3;
        tick(6);
        chk(8'(i_dmahs_if.pci_gnt_n), 8'h03);
        chk(8'(spare_i), 8'h03);
        $display("suspend and spare test done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
